// ==== rtl/fbpu_pkg.sv ====
// Shared constants, codes and carrier types of the flash protection unit.
// Assumes a single 200 MHz system clock and an external nonvolatile array.
package fbpu_pkg;

    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned PS_PER_US = 1000000;
    // Reset value of the clocks-per-microsecond count, from the clock rate
    localparam logic [31:0] USEC_RESET = 32'(PS_PER_US / CLK_PERIOD_PS);
    // Length of the nonvolatile write pulse, in microseconds
    localparam logic [7:0] NV_PULSE_US = 8'h14;
    // Flash blocks are 2 kB, so the block index starts at address bit 11
    localparam int unsigned BLOCK_SHIFT = 11;
    localparam int unsigned NUM_BLOCKS_DEF = 64;

    localparam logic [1:0] PROT_FULL_ACCESS = 2'h0;
    localparam logic [1:0] PROT_NO_MODIFY = 2'h1;
    localparam logic [1:0] PROT_FETCH_ONLY = 2'h2;
    // Erased nonvolatile cells read as all ones
    localparam logic [1:0] PROT_NV_ERASED = 2'h3;

    localparam int unsigned INT_ACCESS = 0;
    localparam int unsigned INT_PROGRAM = 1;

    typedef enum logic [1:0] {
        ST_LOAD, ST_IDLE, ST_PROG
    } fbpu_state_t;

    typedef enum logic [2:0] {
        OP_PROT_SET, OP_PROT_COMMIT, OP_USER_SET, OP_USER_COMMIT, OP_USEC_SET
    } fbpu_op_t;

    typedef enum logic [1:0] {
        ACC_READ, ACC_FETCH, ACC_ERASE, ACC_PROGRAM
    } fbpu_kind_t;

    typedef struct packed {
        logic valid;
        fbpu_op_t op;
        logic [31:0] addr;
        logic [1:0] prot;
        logic [31:0] data0;
        logic [31:0] data1;
    } fbpu_cmd_t;

    typedef struct packed {
        logic valid;
        fbpu_kind_t kind;
        logic [31:0] addr;
    } fbpu_acc_t;

    typedef struct packed {
        logic valid;
        logic err;
    } fbpu_rsp_t;

endpackage

// ==== rtl/fbpu_us_tick.sv ====
// Microsecond tick divider for program, erase and commit timing.
// Assumes the count input is stable while a timed operation runs.
`timescale 1ns/1ps
module fbpu_us_tick (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic [31:0] usec_in,
    output logic tick_out
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } fbpu_tick_st_t;

    fbpu_tick_st_t state_reg;
    fbpu_tick_st_t state_next;

    // A count of zero behaves as one so the tick never stops
    always_comb begin
        state_next = state_reg;
        state_next.tick = 1'b0;
        if (state_reg.cnt + 32'h1 >= usec_in) begin
            state_next.cnt = 32'h0;
            state_next.tick = 1'b1;
        end else begin
            state_next.cnt = state_reg.cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick_out = state_reg.tick;
endmodule

// ==== rtl/fbpu_access_check.sv ====
// Protection lookup for one flash access: block decode and permission.
// Purely combinational; the caller registers the verdict.
`timescale 1ns/1ps
module fbpu_access_check
    import fbpu_pkg::*;
#(
    parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF
) (
    input wire logic [NUM_BLOCKS-1:0][1:0] prot_in,
    input wire logic [31:0] addr_in,
    input wire fbpu_pkg::fbpu_kind_t kind_in,
    output logic hit_out,
    output logic allow_out
);
    import fbpu_pkg::*;

    logic [31:0] idx;
    logic [1:0] prot;

    always_comb begin
        idx = addr_in >> BLOCK_SHIFT;
        hit_out = idx < NUM_BLOCKS;
        prot = hit_out ? prot_in[idx[$clog2(NUM_BLOCKS)-1:0]]
            : PROT_FETCH_ONLY;
        allow_out = 1'b0;
        if (hit_out) begin
            case (kind_in)
                ACC_FETCH: allow_out = 1'b1;
                ACC_READ: allow_out = prot != PROT_FETCH_ONLY;
                ACC_ERASE: allow_out = prot == PROT_FULL_ACCESS;
                ACC_PROGRAM: allow_out = prot == PROT_FULL_ACCESS;
                default: allow_out = 1'b0;
            endcase
        end
    end
endmodule

// ==== rtl/fbpu_top.sv ====
// Flash block protection, user words and timing count, with commit engine.
// Assumes an external nonvolatile array holding the committed copies and
// a separate erase/program datapath that reports its own completion.
//
// Contract
// - Each 2 kB block keeps its own state
// - Full-access block allows all four access kinds
// - No-modify block refuses erase and program
// - Fetch-only block allows instruction fetch only
// - Updates may only tighten a block
// - Fetch-only block ignores all later updates
// - Loosening is blocked and reported failed
// - Uncommitted changes vanish at next reset
// - Protection commit writes nonvolatile copy permanently
// - Violating access raises access interrupt
// - Clocks-per-microsecond count held and readable
// - Count times only program/erase signalling; the code also times the commit write pulse with it
// - Two user words readable at all times
// - User words writable as working copy
// - User commit writes both words permanently
// - Commit shows busy; requester waits completion
// - Internal commit failure reports hardware error
// - Bad address or code rejected with error
// - Per-source enables; raw and masked readable
// - Erase/program completion raises its own interrupt
`timescale 1ns/1ps
module fbpu_top
    import fbpu_pkg::*;
#(
    parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire fbpu_pkg::fbpu_cmd_t cmd_in,
    output fbpu_pkg::fbpu_rsp_t rsp_out,
    output logic busy_out,
    input wire fbpu_pkg::fbpu_acc_t acc_in,
    output logic acc_grant_out,
    output logic acc_deny_out,
    input wire logic [31:0] query_addr_in,
    output logic [1:0] query_prot_out,
    output logic [31:0] user0_out,
    output logic [31:0] user1_out,
    output logic [31:0] clocks_per_microsecond_out,
    output logic us_tick_out,
    input wire logic op_done_in,
    input wire logic [1:0] int_en_in,
    input wire logic [1:0] int_clr_in,
    output logic [1:0] int_raw_out,
    output logic [1:0] int_masked_out,
    output logic irq_out,
    input wire logic [NUM_BLOCKS-1:0][1:0] nv_prot_in,
    input wire logic [31:0] nv_user0_in,
    input wire logic [31:0] nv_user1_in,
    input wire logic nv_err_in,
    output logic nv_wr_out,
    output logic nv_sel_user_out,
    output logic [NUM_BLOCKS-1:0][1:0] nv_prot_wdata_out,
    output logic [31:0] nv_user0_wdata_out,
    output logic [31:0] nv_user1_wdata_out
);
    import fbpu_pkg::*;

    localparam int unsigned IDX_W = $clog2(NUM_BLOCKS);

    typedef struct packed {
        fbpu_state_t st;
        logic [NUM_BLOCKS-1:0][1:0] prot;
        logic [31:0] user0;
        logic [31:0] user1;
        logic [31:0] usec;
        logic [7:0] us_cnt;
        logic sel_user;
        logic nv_wr;
        logic busy;
        logic rsp_valid;
        logic rsp_err;
        logic grant;
        logic deny;
        logic [1:0] raw;
        logic [1:0] masked;
        logic irq;
        logic [1:0] query_prot;
        logic tick;
    } fbpu_top_st_t;

    fbpu_top_st_t state_reg;
    fbpu_top_st_t state_next;

    logic us_tick;
    logic acc_hit;
    logic acc_allow;
    logic [31:0] set_idx;
    logic [31:0] query_idx;
    logic [1:0] cur_prot;
    logic violation;
    logic [1:0] int_set;

    fbpu_us_tick u_us_tick (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .usec_in(state_reg.usec),
        .tick_out(us_tick)
    );

    fbpu_access_check #(
        .NUM_BLOCKS(NUM_BLOCKS)
    ) u_access_check (
        .prot_in(state_reg.prot),
        .addr_in(acc_in.addr),
        .kind_in(acc_in.kind),
        .hit_out(acc_hit),
        .allow_out(acc_allow)
    );

    always_comb begin
        set_idx = cmd_in.addr >> BLOCK_SHIFT;
        query_idx = query_addr_in >> BLOCK_SHIFT;
        cur_prot = state_reg.prot[set_idx[IDX_W-1:0]];
    end

    // Accesses are not judged while the working copy is still loading,
    // otherwise the reset default would briefly open protected blocks.
    always_comb begin
        violation = acc_in.valid && state_reg.st != ST_LOAD && !acc_allow;
        int_set = '0;
        int_set[INT_ACCESS] = violation;
        int_set[INT_PROGRAM] = op_done_in;
    end

    always_comb begin
        state_next = state_reg;
        state_next.rsp_valid = 1'b0;
        state_next.grant = 1'b0;
        state_next.deny = 1'b0;
        state_next.tick = us_tick;

        // Set wins over a clear arriving in the same cycle
        state_next.raw = (state_reg.raw & ~int_clr_in) | int_set;
        state_next.masked = state_next.raw & int_en_in;
        state_next.irq = |state_next.masked;

        if (query_idx < NUM_BLOCKS) begin
            state_next.query_prot = state_reg.prot[query_idx[IDX_W-1:0]];
        end else begin
            state_next.query_prot = PROT_FETCH_ONLY;
        end

        if (acc_in.valid && state_reg.st != ST_LOAD) begin
            state_next.grant = acc_allow;
            state_next.deny = !acc_allow;
        end

        case (state_reg.st)
            ST_LOAD: begin
                // Erased cells mean never committed: full access
                for (int i = 0; i < NUM_BLOCKS; i++) begin
                    if (nv_prot_in[i] == PROT_NV_ERASED) begin
                        state_next.prot[i] = PROT_FULL_ACCESS;
                    end else begin
                        state_next.prot[i] = nv_prot_in[i];
                    end
                end
                state_next.user0 = nv_user0_in;
                state_next.user1 = nv_user1_in;
                state_next.busy = 1'b0;
                state_next.st = ST_IDLE;
            end
            ST_IDLE: begin
                if (cmd_in.valid) begin
                    state_next.rsp_valid = 1'b1;
                    state_next.rsp_err = 1'b0;
                    case (cmd_in.op)
                        OP_PROT_SET: begin
                            if (set_idx >= NUM_BLOCKS ||
                                cmd_in.prot == PROT_NV_ERASED) begin
                                state_next.rsp_err = 1'b1;
                            end else if (cur_prot == PROT_FETCH_ONLY) begin
                                // Locked for good; a repeat is harmless
                                state_next.rsp_err =
                                    cmd_in.prot != PROT_FETCH_ONLY;
                            end else if (cmd_in.prot < cur_prot) begin
                                state_next.rsp_err = 1'b1;
                            end else begin
                                state_next.prot[set_idx[IDX_W-1:0]] =
                                    cmd_in.prot;
                            end
                        end
                        OP_USER_SET: begin
                            state_next.user0 = cmd_in.data0;
                            state_next.user1 = cmd_in.data1;
                        end
                        OP_USEC_SET: begin
                            state_next.usec = cmd_in.data0;
                        end
                        OP_PROT_COMMIT, OP_USER_COMMIT: begin
                            // Answer comes when the pulse has ended
                            state_next.rsp_valid = 1'b0;
                            state_next.sel_user = cmd_in.op == OP_USER_COMMIT;
                            state_next.nv_wr = 1'b1;
                            state_next.busy = 1'b1;
                            state_next.us_cnt = 8'h0;
                            state_next.st = ST_PROG;
                        end
                        default: begin
                            state_next.rsp_err = 1'b1;
                        end
                    endcase
                end
            end
            ST_PROG: begin
                // Pulse length rides on the programmed count, so a wrong
                // count gives a wrong pulse, as software was warned.
                if (us_tick) begin
                    if (state_reg.us_cnt == NV_PULSE_US - 8'h1) begin
                        state_next.nv_wr = 1'b0;
                        state_next.busy = 1'b0;
                        state_next.rsp_valid = 1'b1;
                        state_next.rsp_err = nv_err_in;
                        state_next.st = ST_IDLE;
                    end else begin
                        state_next.us_cnt = state_reg.us_cnt + 8'h1;
                    end
                end
            end
            default: begin
                state_next.st = ST_LOAD;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= '0;
            state_reg.st <= ST_LOAD;
            state_reg.busy <= 1'b1;
            state_reg.usec <= USEC_RESET;
            state_reg.query_prot <= PROT_FETCH_ONLY;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rsp_out.valid = state_reg.rsp_valid;
    assign rsp_out.err = state_reg.rsp_err;
    assign busy_out = state_reg.busy;
    assign acc_grant_out = state_reg.grant;
    assign acc_deny_out = state_reg.deny;
    assign query_prot_out = state_reg.query_prot;
    assign user0_out = state_reg.user0;
    assign user1_out = state_reg.user1;
    assign clocks_per_microsecond_out = state_reg.usec;
    assign us_tick_out = state_reg.tick;
    assign int_raw_out = state_reg.raw;
    assign int_masked_out = state_reg.masked;
    assign irq_out = state_reg.irq;
    assign nv_wr_out = state_reg.nv_wr;
    assign nv_sel_user_out = state_reg.sel_user;
    assign nv_prot_wdata_out = state_reg.prot;
    assign nv_user0_wdata_out = state_reg.user0;
    assign nv_user1_wdata_out = state_reg.user1;
endmodule

// ==== sim/fbpu_nv_model.sv ====
// Nonvolatile store standing behind the protection unit.
// Assumes the unit drives nv_wr for a whole commit pulse.
`timescale 1ns/1ps
module fbpu_nv_model
    import fbpu_pkg::*;
#(
    parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF
) (
    input wire logic clk_sys_in,
    input wire logic nv_wr_in,
    input wire logic nv_sel_user_in,
    input wire logic [NUM_BLOCKS-1:0][1:0] prot_wdata_in,
    input wire logic [31:0] user0_wdata_in,
    input wire logic [31:0] user1_wdata_in,
    input wire logic fail_in,
    output logic [NUM_BLOCKS-1:0][1:0] nv_prot_out,
    output logic [31:0] nv_user0_out,
    output logic [31:0] nv_user1_out,
    output logic nv_err_out
);
    // No reset on purpose: the cells must outlive chip reset
    initial begin
        nv_prot_out = '1;
        nv_user0_out = '1;
        nv_user1_out = '1;
    end
    assign nv_err_out = fail_in;
    always @(posedge clk_sys_in) begin
        if (nv_wr_in && !fail_in) begin
            if (nv_sel_user_in) begin
                nv_user0_out <= user0_wdata_in;
                nv_user1_out <= user1_wdata_in;
            end else begin
                nv_prot_out <= prot_wdata_in;
            end
        end
    end
endmodule

// ==== sim/fbpu_chk.sv ====
// Port-level checks of the protection unit.
// Bound into fbpu_top; sees only its ports.
`timescale 1ns/1ps
module fbpu_chk
    import fbpu_pkg::*;
#(
    parameter int unsigned NUM_BLOCKS = NUM_BLOCKS_DEF
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire fbpu_pkg::fbpu_cmd_t cmd_in,
    input wire fbpu_pkg::fbpu_rsp_t rsp_out,
    input wire logic busy_out,
    input wire fbpu_pkg::fbpu_acc_t acc_in,
    input wire logic acc_grant_out,
    input wire logic acc_deny_out,
    input wire logic [1:0] int_raw_out,
    input wire logic [1:0] int_masked_out,
    input wire logic irq_out,
    input wire logic [31:0] user0_out,
    input wire logic [31:0] user1_out,
    input wire logic [31:0] clocks_per_microsecond_out,
    input wire logic nv_err_in,
    input wire logic nv_wr_out,
    input wire logic nv_sel_user_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);
    logic take;
    logic acc;
    logic in_rng;
    assign take = cmd_in.valid && !busy_out;
    assign acc = acc_in.valid && !busy_out;
    assign in_rng = (acc_in.addr >> BLOCK_SHIFT) < NUM_BLOCKS;
    AST_ONE_VERDICT: assert property (!acc_grant_out || !acc_deny_out)
        else $error("grant and deny together");
    AST_ACC_ANSWER: assert property (acc |=>
        acc_grant_out || acc_deny_out) else $error("access not answered");
    AST_FETCH_OK: assert property (acc && in_rng &&
        acc_in.kind == ACC_FETCH |=> acc_grant_out)
        else $error("fetch refused");
    AST_OUT_DENY: assert property (acc && !in_rng |=> acc_deny_out)
        else $error("unmapped access granted");
    AST_DENY_RAW: assert property (acc_deny_out |->
        int_raw_out[INT_ACCESS]) else $error("deny without status");
    AST_IRQ: assert property (irq_out == |int_masked_out &&
        (int_masked_out & ~int_raw_out) == 2'h0) else $error("irq mismatch");
    AST_SET_RSP: assert property (take &&
        cmd_in.op inside {OP_PROT_SET, OP_USER_SET, OP_USEC_SET}
        |=> rsp_out.valid) else $error("no answer");
    AST_USER_SET: assert property (take && cmd_in.op == OP_USER_SET
        |=> user0_out == $past(cmd_in.data0) &&
        user1_out == $past(cmd_in.data1)) else $error("user words wrong");
    AST_USEC_SET: assert property (take && cmd_in.op == OP_USEC_SET
        |=> clocks_per_microsecond_out == $past(cmd_in.data0))
        else $error("count wrong");
    AST_PCOMMIT: assert property (take && cmd_in.op == OP_PROT_COMMIT
        |=> busy_out && nv_wr_out && !nv_sel_user_out)
        else $error("bad commit");
    AST_UCOMMIT: assert property (take && cmd_in.op == OP_USER_COMMIT
        |=> busy_out && nv_wr_out && nv_sel_user_out)
        else $error("bad commit");
    AST_PULSE_MIN: assert property ($rose(nv_wr_out) |->
        nv_wr_out[*8]) else $error("pulse short");
    AST_COMMIT_END: assert property ($fell(nv_wr_out) |->
        rsp_out.valid && !busy_out && rsp_out.err == $past(nv_err_in))
        else $error("bad end");
    cover property (acc_deny_out);
    cover property ($fell(nv_wr_out) && !rsp_out.err);
    cover property (irq_out);
endmodule
bind fbpu_top fbpu_chk #(.NUM_BLOCKS(NUM_BLOCKS)) u_chk (
    .clk_sys_in, .rst_n_in, .cmd_in, .rsp_out, .busy_out, .acc_in,
    .acc_grant_out, .acc_deny_out, .int_raw_out, .int_masked_out, .irq_out,
    .user0_out, .user1_out, .clocks_per_microsecond_out, .nv_err_in,
    .nv_wr_out, .nv_sel_user_out
);

// ==== sim/testbench.sv ====
// Self-checking bench for the flash protection unit.
// Inputs change on falling edges; answers are checked against queues.
`timescale 1ns/1ps
module testbench;
    import fbpu_pkg::*;
    localparam int unsigned NB = 4;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    fbpu_cmd_t cmd_in = '0;
    fbpu_acc_t acc_in = '0;
    fbpu_rsp_t rsp_out;
    logic busy_out, acc_grant_out, acc_deny_out, irq_out, nv_err_in, us_tick;
    logic op_done_in = 1'b0, fail = 1'b0, nv_wr_out, nv_sel_user_out;
    logic [1:0] int_en_in = 2'h1, int_clr_in = 2'h0, query_prot_out;
    logic [1:0] int_raw_out, int_masked_out;
    logic [31:0] query_addr_in = '0, user0_out, user1_out, usec;
    logic [31:0] nv_user0_in, nv_user1_in, nv_user0_wdata_out;
    logic [31:0] nv_user1_wdata_out, exp_u0, exp_u1;
    logic [NB-1:0][1:0] nv_prot_in, nv_prot_wdata_out;
    int mismatches = 0, cmp_count = 0, cycles = 0, seed = 29, tick_cnt = 0;
    logic [1:0] exp_prot [NB] = '{default: 2'h0}, com_prot [NB];
    logic exp_err_q [$], exp_grant_q [$];
    // Walks through tightening, loosening, fetch-only, bad code, bad block
    logic [7:0] sets [11] = '{8'h01, 8'h00, 8'h02, 8'h01, 8'h00, 8'h02,
        8'h11, 8'h11, 8'h10, 8'h33, 8'h41};
    fbpu_top #(.NUM_BLOCKS(NB)) dut (.clk_sys_in, .rst_n_in, .cmd_in,
        .rsp_out, .busy_out, .acc_in, .acc_grant_out, .acc_deny_out,
        .query_addr_in, .query_prot_out, .user0_out, .user1_out,
        .clocks_per_microsecond_out(usec), .us_tick_out(us_tick), .op_done_in,
        .int_en_in, .int_clr_in, .int_raw_out, .int_masked_out, .irq_out,
        .nv_prot_in, .nv_user0_in, .nv_user1_in, .nv_err_in, .nv_wr_out,
        .nv_sel_user_out, .nv_prot_wdata_out, .nv_user0_wdata_out,
        .nv_user1_wdata_out);
    fbpu_nv_model #(.NUM_BLOCKS(NB)) nv (.clk_sys_in,
        .nv_wr_in(nv_wr_out), .nv_sel_user_in(nv_sel_user_out),
        .prot_wdata_in(nv_prot_wdata_out), .user0_wdata_in(nv_user0_wdata_out),
        .user1_wdata_in(nv_user1_wdata_out), .fail_in(fail),
        .nv_prot_out(nv_prot_in), .nv_user0_out(nv_user0_in),
        .nv_user1_out(nv_user1_in), .nv_err_out(nv_err_in));
    always #2.5 clk_sys_in = ~clk_sys_in;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [31:0] addr_of(input int b);
        return (32'(b) << BLOCK_SHIFT) | (32'($random(seed)) & 32'h7ff);
    endfunction
    function automatic logic prot_upd(input int b, input logic [1:0] p);
        if (b >= NB || p == PROT_NV_ERASED || p < exp_prot[b])
            return 1'b1;
        exp_prot[b] = p;
        return 1'b0;
    endfunction
    function automatic logic allow(input int b, input int k);
        if (b >= NB) return 1'b0;
        if (k == ACC_FETCH) return 1'b1;
        if (k == ACC_READ) return exp_prot[b] != PROT_FETCH_ONLY;
        return exp_prot[b] == PROT_FULL_ACCESS;
    endfunction
    task automatic wait_idle;
        for (int n = 0; n < 200 && busy_out !== 1'b0; n++)
            @(negedge clk_sys_in);
        chk(busy_out, 1'b0);
    endtask
    task automatic do_reset;
        rst_n_in = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        @(negedge clk_sys_in);
        wait_idle();
    endtask
    task automatic send(input fbpu_op_t op, input int b, input logic [1:0] p,
        input logic [31:0] d0, input logic [31:0] d1, input logic err);
        @(negedge clk_sys_in);
        cmd_in = '{1'b1, op, addr_of(b), p, d0, d1};
        exp_err_q.push_back(err);
        @(negedge clk_sys_in);
        cmd_in.valid = 1'b0;
    endtask
    task automatic run_acc;
        for (int b = 0; b <= NB; b++) begin
            for (int k = 0; k < 4; k++) begin
                @(negedge clk_sys_in);
                acc_in = '{1'b1, fbpu_kind_t'(k), addr_of(b)};
                exp_grant_q.push_back(allow(b, k));
            end
        end
        @(negedge clk_sys_in);
        acc_in.valid = 1'b0;
    endtask
    task automatic query_all;
        for (int b = 0; b < NB; b++) begin
            query_addr_in = addr_of(b);
            @(negedge clk_sys_in);
            chk(query_prot_out, exp_prot[b]);
        end
    endtask
    always @(negedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
        if (rsp_out.valid === 1'b1)
            chk(rsp_out.err, exp_err_q.pop_front());
        if (acc_grant_out === 1'b1 || acc_deny_out === 1'b1)
            chk(acc_grant_out, exp_grant_q.pop_front());
    end
    initial begin
        do_reset();
        query_all();
        chk(usec, USEC_RESET);
        // Any 400-cycle window holds exactly two ticks at the reset count
        repeat (400) begin
            @(negedge clk_sys_in);
            tick_cnt += us_tick;
        end
        chk(tick_cnt, 32'h2);
        send(OP_USEC_SET, 0, 2'h0, 32'h1, 32'h0, 1'b0);
        chk(usec, 32'h1);
        repeat (2) @(negedge clk_sys_in);
        chk(us_tick, 1'b1);
        foreach (sets[i]) begin
            @(negedge clk_sys_in);
            cmd_in = '{1'b1, OP_PROT_SET, addr_of(sets[i][7:4]), sets[i][1:0],
                32'h0, 32'h0};
            exp_err_q.push_back(prot_upd(sets[i][7:4], sets[i][1:0]));
        end
        @(negedge clk_sys_in);
        cmd_in.valid = 1'b0;
        run_acc();
        chk(int_raw_out, 2'h1);
        chk(irq_out, 1'b1);
        int_en_in = 2'h0;
        @(negedge clk_sys_in);
        chk(irq_out, 1'b0);
        int_clr_in = 2'h1;
        @(negedge clk_sys_in);
        int_clr_in = 2'h0;
        op_done_in = 1'b1;
        @(negedge clk_sys_in);
        op_done_in = 1'b0;
        int_en_in = 2'h2;
        @(negedge clk_sys_in);
        chk(int_raw_out, 2'h2);
        chk(int_masked_out, 2'h2);
        chk(irq_out, 1'b1);
        exp_u0 = $random(seed);
        exp_u1 = $random(seed);
        send(OP_USER_SET, 0, 2'h0, exp_u0, exp_u1, 1'b0);
        chk(user0_out, exp_u0);
        chk(user1_out, exp_u1);
        // A failing pulse must leave the stored copy untouched
        fail = 1'b1;
        send(OP_PROT_COMMIT, 0, 2'h0, 32'h0, 32'h0, 1'b1);
        wait_idle();
        chk(32'(nv_prot_in), 32'hff);
        fail = 1'b0;
        send(OP_PROT_COMMIT, 0, 2'h0, 32'h0, 32'h0, 1'b0);
        wait_idle();
        com_prot = exp_prot;
        send(OP_USER_COMMIT, 0, 2'h0, 32'h0, 32'h0, 1'b0);
        wait_idle();
        send(OP_PROT_SET, 2, PROT_NO_MODIFY, 32'h0, 32'h0, prot_upd(2, 2'h1));
        send(OP_USER_SET, 0, 2'h0, ~exp_u0, ~exp_u1, 1'b0);
        do_reset();
        exp_prot = com_prot;
        query_all();
        chk(user0_out, exp_u0);
        chk(user1_out, exp_u1);
        run_acc();
        // Let the monitor take the last answer before the verdict
        @(negedge clk_sys_in);
        chk(exp_err_q.size(), 32'h0);
        chk(exp_grant_q.size(), 32'h0);
        report_and_stop();
    end
endmodule
